// ---- inc/hsp_pkg.sv ----
`default_nettype none
package hsp_pkg;
	// =========================================================
	// clock and rate generation
	localparam logic [31:0] CLK_HZ        = 32'h0131_2D00; // 20 MHz core clock
	localparam int          DIV_W         = 20;            // cycles per bit, down to 57 b/s
	localparam int          STD_RATE [8]  = '{1200, 2400, 4800, 9600, 19200, 38400, 57600, 115200};
	localparam int          DIV_STEPS     = 32;            // iterations of the rate divider

	// =========================================================
	// settings: selects, reset values and legal ranges
	localparam logic [1:0]  SEL_RATE      = 2'h0;
	localparam logic [1:0]  SEL_PARITY    = 2'h1;
	localparam logic [1:0]  SEL_TIMEOUT   = 2'h2;
	localparam logic [31:0] RATE_RESET    = 32'h0000_0003;
	localparam logic [31:0] RATE_STD_MAX  = 32'h0000_0007;
	localparam logic [31:0] RATE_NS_MIN   = 32'h0000_0039;
	localparam logic [31:0] RATE_NS_MAX   = 32'h000F_4240;
	localparam logic [7:0]  PARITY_RESET  = 8'h00;
	localparam logic [7:0]  PARITY_MAX    = 8'h04;
	localparam logic [7:0]  TIMEOUT_RESET = 8'h03;
	localparam logic [1:0]  FRAMING_RAW   = 2'h0;
	localparam logic [3:0]  FRAME_BITS    = 4'hA;          // start, 8 data, stop
	localparam logic [3:0]  FRAME_BITS_P  = 4'hB;          // with parity bit

	// =========================================================
	// types
	typedef enum logic [2:0] {
		PAR_NONE  = 3'h0,
		PAR_EVEN  = 3'h1,
		PAR_ODD   = 3'h2,
		PAR_MARK  = 3'h3,
		PAR_SPACE = 3'h4
	} hsp_parity_type;

	typedef struct packed {
		logic        wr;
		logic [1:0]  sel;
		logic [31:0] data;
	} hsp_cfg_wr_type;

	typedef struct packed {
		logic [7:0] data;
		logic       last;
	} hsp_byte_type;

	// =========================================================
	// helpers
	function automatic logic [DIV_W-1:0] hsp_std_div(input logic [2:0] code);
		int r;
		r = STD_RATE[code];
		return DIV_W'((CLK_HZ + r / 2) / r);
	endfunction : hsp_std_div

	function automatic logic hsp_par_bit(input hsp_parity_type p, input logic [7:0] d);
		logic b;
		unique case (p)
			PAR_EVEN: b = ^d;
			PAR_ODD:  b = ~^d;
			PAR_MARK: b = 1'b1;
			default:  b = 1'b0;
		endcase
		return b;
	endfunction : hsp_par_bit
endpackage : hsp_pkg
`default_nettype wire

// ---- logic/hsp_fifo.sv ----
`default_nettype none
module hsp_fifo
	import hsp_pkg::*;
#(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
)(
	input  wire logic             core_clk_in,
	input  wire logic             rst_n_in,
	input  wire logic             in_valid_in,
	input  wire logic [WIDTH-1:0] in_data_in,
	output logic                  in_ready_out,
	output logic                  out_valid_out,
	output logic      [WIDTH-1:0] out_data_out,
	input  wire logic             out_ready_in
);
	localparam int AW = $clog2(DEPTH);

	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
		$error("hsp_fifo: DEPTH must be a power of two, at least 2");

	// =========================================================
	// storage, pointers and registered read stage
	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0]    wr_ptr_reg, wr_ptr_next;
	logic [AW-1:0]    rd_ptr_reg, rd_ptr_next;
	logic [AW:0]      cnt_reg, cnt_next;
	logic             ready_reg, ready_next;
	logic             ovalid_reg, ovalid_next;
	logic [WIDTH-1:0] odata_reg, odata_next;
	logic             wr_en;
	logic             ld_en;

	// the read stage refills whenever it is empty or being taken
	always_comb begin
		wr_en       = in_valid_in && ready_reg;
		ld_en       = (cnt_reg != '0) && (!ovalid_reg || out_ready_in);
		wr_ptr_next = wr_en ? wr_ptr_reg + 1'b1 : wr_ptr_reg;
		rd_ptr_next = ld_en ? rd_ptr_reg + 1'b1 : rd_ptr_reg;
		cnt_next    = cnt_reg + {{AW{1'b0}}, wr_en} - {{AW{1'b0}}, ld_en};
		ready_next  = cnt_next != (AW + 1)'(DEPTH); // full holds the source off
		odata_next  = ld_en ? mem_reg[rd_ptr_reg] : odata_reg;
		ovalid_next = ld_en ? 1'b1 : (out_ready_in ? 1'b0 : ovalid_reg);
	end

	always_ff @(posedge core_clk_in) begin
		if (wr_en) begin
			mem_reg[wr_ptr_reg] <= in_data_in;
		end
		if (!rst_n_in) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			cnt_reg    <= '0;
			ready_reg  <= 1'b1;
			ovalid_reg <= 1'b0;
			odata_reg  <= '0;
		end else begin
			wr_ptr_reg <= wr_ptr_next;
			rd_ptr_reg <= rd_ptr_next;
			cnt_reg    <= cnt_next;
			ready_reg  <= ready_next;
			ovalid_reg <= ovalid_next;
			odata_reg  <= odata_next;
		end
	end

	assign in_ready_out  = ready_reg;
	assign out_valid_out = ovalid_reg;
	assign out_data_out  = odata_reg;
endmodule : hsp_fifo
`default_nettype wire

// ---- logic/hsp_serial_port.sv ----
// What this block does
// - rate codes 0-7 pick standard rates, reset 3
// - non-standard rate snaps to nearest achievable rate
// - parity none/even/odd/mark/space, reset none
// - flush buffer after programmed silent character times
// - zero timeout sends each character at once
// - framing mode 0: raw bytes, silence splits
`default_nettype none
module hsp_serial_port
	import hsp_pkg::*;
#(
	parameter int FIFO_DEPTH = 16
)(
	input  wire logic           core_clk_in,
	input  wire logic           rst_n_in,
	input  wire hsp_cfg_wr_type cfg_in,
	output logic         [31:0] cfg_rdata_out,
	output logic                cfg_busy_out,
	input  wire logic     [1:0] framing_mode_in,
	input  wire logic           serial_rx_in,
	output logic                serial_tx_out,
	output logic                serial_rx_ready_out,
	output logic                rx_error_out,
	output hsp_byte_type        rf_tx_out,
	output logic                rf_tx_valid_out,
	input  wire logic           rf_tx_ready_in,
	input  wire logic     [7:0] rf_rx_data_in,
	input  wire logic           rf_rx_valid_in,
	output logic                rf_rx_ready_out
);
	localparam int CW = $clog2(FIFO_DEPTH + 2);

	if (FIFO_DEPTH < 2 || FIFO_DEPTH > 64)
		$error("hsp_serial_port: FIFO_DEPTH out of range 2..64");

	// =========================================================
	// settings and rate divider
	typedef enum logic [1:0] {
		D_IDLE = 2'h0,
		D_DIV1 = 2'h1,
		D_DIV2 = 2'h2
	} hsp_dstate_type;

	hsp_dstate_type   dstate_reg, dstate_next;
	logic [31:0]      rate_reg, rate_next;
	logic [7:0]       parity_reg, parity_next;
	logic [7:0]       timeout_reg, timeout_next;
	logic [DIV_W-1:0] div_reg, div_next;
	logic [31:0]      num_reg, num_next;
	logic [31:0]      den_reg, den_next;
	logic [32:0]      rem_reg, rem_next;
	logic [31:0]      quo_reg, quo_next;
	logic [4:0]       step_reg, step_next;
	logic [31:0]      rdata_reg, rdata_next;
	logic [32:0]      rem_t;
	logic [31:0]      quo_t;
	hsp_parity_type   par_mode;

	// the rate is computed in 64 cycles; writes during that time are dropped
	always_comb begin
		dstate_next  = dstate_reg;
		rate_next    = rate_reg;
		parity_next  = parity_reg;
		timeout_next = timeout_reg;
		div_next     = div_reg;
		num_next     = {num_reg[30:0], 1'b0};
		den_next     = den_reg;
		step_next    = step_reg + 1'b1;
		rem_t        = {rem_reg[31:0], num_reg[31]};
		rem_next     = rem_t;
		quo_t        = {quo_reg[30:0], 1'b0};
		if (rem_t >= {1'b0, den_reg}) begin
			rem_next = rem_t - {1'b0, den_reg};
			quo_t    = {quo_reg[30:0], 1'b1};
		end
		quo_next = quo_t;
		unique case (dstate_reg)
			D_IDLE: begin
				step_next = '0;
				rem_next  = '0;
				quo_next  = '0;
				num_next  = num_reg;
				if (cfg_in.wr) begin
					unique case (cfg_in.sel)
						SEL_RATE: begin
							if (cfg_in.data <= RATE_STD_MAX) begin
								rate_next = cfg_in.data;
								div_next  = hsp_std_div(cfg_in.data[2:0]);
							end else if (cfg_in.data >= RATE_NS_MIN
								&& cfg_in.data <= RATE_NS_MAX) begin
								num_next    = CLK_HZ + {1'b0, cfg_in.data[31:1]};
								den_next    = cfg_in.data;
								dstate_next = D_DIV1;
							end
						end
						SEL_PARITY: if (cfg_in.data <= {24'h0, PARITY_MAX}) parity_next = cfg_in.data[7:0];
						SEL_TIMEOUT: timeout_next = cfg_in.data[7:0];
						default: ;
					endcase
				end
			end
			D_DIV1: if (step_reg == 5'(DIV_STEPS - 1)) begin
				div_next    = quo_t[DIV_W-1:0];
				num_next    = CLK_HZ + {1'b0, quo_t[31:1]};
				den_next    = quo_t;
				rem_next    = '0;
				quo_next    = '0;
				dstate_next = D_DIV2;
			end
			D_DIV2: if (step_reg == 5'(DIV_STEPS - 1)) begin
				rate_next   = quo_t;
				dstate_next = D_IDLE;
			end
			default: dstate_next = D_IDLE;
		endcase
		unique case (cfg_in.sel)
			SEL_RATE:    rdata_next = rate_reg;
			SEL_PARITY:  rdata_next = {24'h0, parity_reg};
			SEL_TIMEOUT: rdata_next = {24'h0, timeout_reg};
			default:     rdata_next = '0;
		endcase
	end

	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			dstate_reg  <= D_IDLE;
			rate_reg    <= RATE_RESET;
			parity_reg  <= PARITY_RESET;
			timeout_reg <= TIMEOUT_RESET;
			div_reg     <= hsp_std_div(RATE_RESET[2:0]);
			num_reg     <= '0;
			den_reg     <= 32'h0000_0001;
			rem_reg     <= '0;
			quo_reg     <= '0;
			step_reg    <= '0;
			rdata_reg   <= '0;
		end else begin
			dstate_reg  <= dstate_next;
			rate_reg    <= rate_next;
			parity_reg  <= parity_next;
			timeout_reg <= timeout_next;
			div_reg     <= div_next;
			num_reg     <= num_next;
			den_reg     <= den_next;
			rem_reg     <= rem_next;
			quo_reg     <= quo_next;
			step_reg    <= step_next;
			rdata_reg   <= rdata_next;
		end
	end

	assign par_mode      = hsp_parity_type'(parity_reg[2:0]);
	assign cfg_rdata_out = rdata_reg;
	assign cfg_busy_out  = dstate_reg != D_IDLE;

	// =========================================================
	// receiver: samples each bit in its middle
	typedef enum logic [2:0] {
		RX_IDLE  = 3'h0,
		RX_START = 3'h1,
		RX_DATA  = 3'h2,
		RX_PAR   = 3'h3,
		RX_STOP  = 3'h4
	} hsp_rxstate_type;

	hsp_rxstate_type  rx_state_reg, rx_state_next;
	logic [DIV_W-1:0] rx_cnt_reg, rx_cnt_next;
	logic [2:0]       rx_bit_reg, rx_bit_next;
	logic [7:0]       rx_shift_reg, rx_shift_next;
	logic             rx_pok_reg, rx_pok_next;
	logic             rx_push_reg, rx_push_next;
	logic             rx_err_reg, rx_err_next;

	always_comb begin
		rx_state_next = rx_state_reg;
		rx_cnt_next   = rx_cnt_reg - 1'b1;
		rx_bit_next   = rx_bit_reg;
		rx_shift_next = rx_shift_reg;
		rx_pok_next   = rx_pok_reg;
		rx_push_next  = 1'b0;
		rx_err_next   = 1'b0;
		unique case (rx_state_reg)
			RX_IDLE: begin
				rx_cnt_next = {1'b0, div_reg[DIV_W-1:1]};
				rx_pok_next = 1'b1;
				if (!serial_rx_in) rx_state_next = RX_START;
			end
			RX_START: if (rx_cnt_reg == '0) begin
				rx_cnt_next   = div_reg - 1'b1;
				rx_bit_next   = '0;
				rx_state_next = serial_rx_in ? RX_IDLE : RX_DATA;
			end
			RX_DATA: if (rx_cnt_reg == '0) begin
				rx_cnt_next   = div_reg - 1'b1;
				rx_shift_next = {serial_rx_in, rx_shift_reg[7:1]};
				rx_bit_next   = rx_bit_reg + 1'b1;
				if (rx_bit_reg == 3'h7) rx_state_next = (par_mode == PAR_NONE) ? RX_STOP : RX_PAR;
			end
			RX_PAR: if (rx_cnt_reg == '0) begin
				rx_cnt_next   = div_reg - 1'b1;
				rx_pok_next   = serial_rx_in == hsp_par_bit(par_mode, rx_shift_reg);
				rx_state_next = RX_STOP;
			end
			RX_STOP: if (rx_cnt_reg == '0) begin
				rx_push_next  = serial_rx_in && rx_pok_reg;
				rx_err_next   = !(serial_rx_in && rx_pok_reg);
				rx_state_next = RX_IDLE;
			end
			default: rx_state_next = RX_IDLE;
		endcase
	end

	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			rx_state_reg <= RX_IDLE;
			rx_cnt_reg   <= '0;
			rx_bit_reg   <= '0;
			rx_shift_reg <= '0;
			rx_pok_reg   <= 1'b1;
			rx_push_reg  <= 1'b0;
			rx_err_reg   <= 1'b0;
		end else begin
			rx_state_reg <= rx_state_next;
			rx_cnt_reg   <= rx_cnt_next;
			rx_bit_reg   <= rx_bit_next;
			rx_shift_reg <= rx_shift_next;
			rx_pok_reg   <= rx_pok_next;
			rx_push_reg  <= rx_push_next;
			rx_err_reg   <= rx_err_next;
		end
	end

	assign rx_error_out = rx_err_reg;

	// =========================================================
	// buffer and silence packetizer
	logic               fifo_in_ready;
	logic               fifo_out_valid;
	logic               fifo_out_ready;
	logic         [7:0] fifo_out_data;
	logic               push_acc;
	logic               flush;
	logic               pop;
	logic [DIV_W+3:0]   char_cyc;
	logic [DIV_W+3:0]   sil_cyc_reg, sil_cyc_next;
	logic [7:0]         sil_chars_reg, sil_chars_next;
	logic [CW-1:0]      unfl_reg, unfl_next;
	logic [CW-1:0]      rel_reg, rel_next;
	hsp_byte_type       txo_reg, txo_next;
	logic               txo_valid_reg, txo_valid_next;

	// only raw framing feeds the packetizer; a full buffer drops the byte
	assign push_acc = rx_push_reg && framing_mode_in == FRAMING_RAW && fifo_in_ready;

	hsp_fifo #(
		.WIDTH (8),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.core_clk_in   (core_clk_in),
		.rst_n_in      (rst_n_in),
		.in_valid_in   (push_acc),
		.in_data_in    (rx_shift_reg),
		.in_ready_out  (fifo_in_ready),
		.out_valid_out (fifo_out_valid),
		.out_data_out  (fifo_out_data),
		.out_ready_in  (fifo_out_ready)
	);

	// one packet at a time is released, so the last flag is exact
	always_comb begin
		char_cyc = (DIV_W + 4)'(div_reg) * (DIV_W + 4)'((par_mode == PAR_NONE) ? FRAME_BITS : FRAME_BITS_P);
		fifo_out_ready = (rel_reg != '0) && (!txo_valid_reg || rf_tx_ready_in);
		pop   = fifo_out_valid && fifo_out_ready;
		flush = (rel_reg == '0) && (unfl_reg != '0)
			&& (timeout_reg == 8'h00
			|| sil_chars_reg >= timeout_reg
			|| unfl_reg >= CW'(FIFO_DEPTH));
		sil_cyc_next   = sil_cyc_reg + 1'b1;
		sil_chars_next = sil_chars_reg;
		if (push_acc || rx_state_reg != RX_IDLE) begin
			sil_cyc_next   = '0;
			sil_chars_next = '0;
		end else if (sil_cyc_reg >= char_cyc - 1'b1) begin
			sil_cyc_next = '0;
			if (sil_chars_reg != 8'hFF) sil_chars_next = sil_chars_reg + 1'b1;
		end
		unfl_next = (flush ? '0 : unfl_reg) + CW'(push_acc);
		rel_next  = flush ? unfl_reg : rel_reg - CW'(pop);
		txo_next  = txo_reg;
		txo_valid_next = rf_tx_ready_in ? 1'b0 : txo_valid_reg;
		if (pop) begin
			txo_next.data  = fifo_out_data;
			txo_next.last  = rel_reg == CW'(1);
			txo_valid_next = 1'b1;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			sil_cyc_reg   <= '0;
			sil_chars_reg <= '0;
			unfl_reg      <= '0;
			rel_reg       <= '0;
			txo_reg       <= '0;
			txo_valid_reg <= 1'b0;
		end else begin
			sil_cyc_reg   <= sil_cyc_next;
			sil_chars_reg <= sil_chars_next;
			unfl_reg      <= unfl_next;
			rel_reg       <= rel_next;
			txo_reg       <= txo_next;
			txo_valid_reg <= txo_valid_next;
		end
	end

	assign rf_tx_out           = txo_reg;
	assign rf_tx_valid_out     = txo_valid_reg;
	assign serial_rx_ready_out = fifo_in_ready;

	// =========================================================
	// transmitter toward the host; frame bit 0 is the line itself
	typedef enum logic {
		TX_IDLE = 1'b0,
		TX_SEND = 1'b1
	} hsp_txstate_type;

	hsp_txstate_type  tx_state_reg, tx_state_next;
	logic [10:0]      tx_frame_reg, tx_frame_next;
	logic [3:0]       tx_left_reg, tx_left_next;
	logic [DIV_W-1:0] tx_cnt_reg, tx_cnt_next;
	logic             tx_rdy_reg, tx_rdy_next;

	always_comb begin
		tx_state_next = tx_state_reg;
		tx_frame_next = tx_frame_reg;
		tx_left_next  = tx_left_reg;
		tx_cnt_next   = tx_cnt_reg - 1'b1;
		unique case (tx_state_reg)
			TX_IDLE: if (rf_rx_valid_in && tx_rdy_reg) begin
				tx_frame_next = (par_mode == PAR_NONE)
					? {2'b11, rf_rx_data_in, 1'b0}
					: {1'b1, hsp_par_bit(par_mode, rf_rx_data_in), rf_rx_data_in, 1'b0};
				tx_left_next  = (par_mode == PAR_NONE) ? FRAME_BITS : FRAME_BITS_P;
				tx_cnt_next   = div_reg - 1'b1;
				tx_state_next = TX_SEND;
			end
			TX_SEND: if (tx_cnt_reg == '0) begin
				tx_frame_next = {1'b1, tx_frame_reg[10:1]};
				tx_left_next  = tx_left_reg - 1'b1;
				tx_cnt_next   = div_reg - 1'b1;
				if (tx_left_reg == 4'h1) tx_state_next = TX_IDLE;
			end
			default: tx_state_next = TX_IDLE;
		endcase
		tx_rdy_next = tx_state_next == TX_IDLE && !(rf_rx_valid_in && tx_rdy_reg);
	end

	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			tx_state_reg <= TX_IDLE;
			tx_frame_reg <= '1;
			tx_left_reg  <= '0;
			tx_cnt_reg   <= '0;
			tx_rdy_reg   <= 1'b0;
		end else begin
			tx_state_reg <= tx_state_next;
			tx_frame_reg <= tx_frame_next;
			tx_left_reg  <= tx_left_next;
			tx_cnt_reg   <= tx_cnt_next;
			tx_rdy_reg   <= tx_rdy_next;
		end
	end

	assign serial_tx_out   = tx_frame_reg[0];
	assign rf_rx_ready_out = tx_rdy_reg;

	// =========================================================
	// checks
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!rst_n_in);

	property p_rate_reset;
		$rose(rst_n_in) |-> rate_reg == RATE_RESET && div_reg == hsp_std_div(3'h3);
	endproperty
	a_rate_reset: assert property (p_rate_reset) else $error("rate not at reset code");

	property p_std_div;
		(dstate_reg == D_IDLE && rate_reg <= RATE_STD_MAX) |-> div_reg == hsp_std_div(rate_reg[2:0]);
	endproperty
	a_std_div: assert property (p_std_div) else $error("standard code with wrong divisor");

	property p_ns_bad;
		(dstate_reg == D_IDLE && cfg_in.wr && cfg_in.sel == SEL_RATE && cfg_in.data > RATE_STD_MAX
			&& cfg_in.data < RATE_NS_MIN) |=> $stable(rate_reg) && dstate_reg == D_IDLE;
	endproperty
	a_ns_bad: assert property (p_ns_bad) else $error("illegal rate accepted");

	sequence s_ns_start;
		dstate_reg == D_IDLE && cfg_in.wr && cfg_in.sel == SEL_RATE
			&& cfg_in.data >= RATE_NS_MIN && cfg_in.data <= RATE_NS_MAX;
	endsequence
	property p_ns_done;
		s_ns_start |-> ##65 (dstate_reg == D_IDLE && rate_reg >= 32'h0000_0039);
	endproperty
	a_ns_done: assert property (p_ns_done) else $error("snapped rate not stored in time");

	property p_readback;
		(cfg_in.sel == SEL_RATE) |=> cfg_rdata_out == $past(rate_reg);
	endproperty
	a_readback: assert property (p_readback) else $error("rate readback differs");

	property p_parity_bad;
		(dstate_reg == D_IDLE && cfg_in.wr && cfg_in.sel == SEL_PARITY
			&& cfg_in.data > {24'h0, PARITY_MAX}) |=> $stable(parity_reg);
	endproperty
	a_parity_bad: assert property (p_parity_bad) else $error("illegal parity accepted");

	property p_silence;
		(flush && timeout_reg != 8'h00 && unfl_reg < CW'(FIFO_DEPTH)) |-> sil_chars_reg >= timeout_reg;
	endproperty
	a_silence: assert property (p_silence) else $error("packet released too early");

	property p_zero_timeout;
		(push_acc && timeout_reg == 8'h00 && rel_reg == '0) |=> flush;
	endproperty
	a_zero_timeout: assert property (p_zero_timeout) else $error("character held at zero timeout");

	property p_raw_only;
		(framing_mode_in != FRAMING_RAW) |-> !push_acc;
	endproperty
	a_raw_only: assert property (p_raw_only) else $error("byte buffered outside raw framing");

	property p_tx_start;
		(tx_state_reg == TX_IDLE && rf_rx_valid_in && tx_rdy_reg) |=> !serial_tx_out [*8];
	endproperty
	a_tx_start: assert property (p_tx_start) else $error("start bit not low");
endmodule : hsp_serial_port
`default_nettype wire

// ---- testbench/hsp_host_model.sv ----
`default_nettype none
// =========================================================
// host controller across the serial link
module hsp_host_model (
	input  wire logic clk_in,
	input  wire logic line_in,
	output logic      line_out
);
	timeunit 1ns;
	timeprecision 1ns;
	int div = 174;
	// line idles high between frames
	initial line_out = 1'b1;

	// parity bit for codes 1..4, zero otherwise
	function automatic logic pbit(input int p, input logic [7:0] d);
		return (p == 1) ? ^d : (p == 2) ? ~^d : (p == 3);
	endfunction : pbit

	// one frame; bad inverts the parity bit to provoke an error
	task automatic send(input logic [7:0] d, input int p, input bit bad);
		logic [10:0] f;
		int          n;
		f = {1'b1, pbit(p, d) ^ bad, d, 1'b0};
		n = (p == 0) ? 10 : 11;
		if (p == 0) begin
			f[9] = 1'b1;
		end
		for (int i = 0; i < n; i++) begin
			@(negedge clk_in);
			line_out = f[i];
			repeat (div - 1) @(negedge clk_in);
		end
	endtask : send

	// sample mid-bit; returns {stop, parity, data}
	task automatic recv(output logic [9:0] f, input int p);
		f = '0;
		@(negedge line_in);
		repeat (div / 2) @(posedge clk_in);
		for (int i = 0; i < 10; i++) begin
			if (i != 8 || p != 0) begin
				repeat (div) @(posedge clk_in);
				f[i] = line_in;
			end
		end
	endtask : recv
endmodule : hsp_host_model
`default_nettype wire

// ---- testbench/test_host_serial_port_packetizer.sv ----
`default_nettype none
module test_host_serial_port_packetizer
	import hsp_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	// =========================================================
	// signals
	logic           core_clk = 1'b0;
	logic           rst_n    = 1'b0;
	hsp_cfg_wr_type cfg      = '0;
	logic     [1:0] fmode    = 2'h0;
	logic     [7:0] rr_d     = 8'h00;
	logic           rr_v     = 1'b0;
	logic           rf_rdy   = 1'b0;
	logic    [31:0] seed     = 32'h574A;
	logic    [31:0] rdata;
	logic           busy, rx, tx, rx_rdy, err, rfv, rr_rdy;
	hsp_byte_type   rft;
	int             miscompares = 0;
	int             num_checks  = 0;
	int             errs        = 0;
	bit             hold        = 1'b0;
	logic     [8:0] exp_q[$];

	always #25 core_clk = ~core_clk;

	hsp_serial_port DUT (.core_clk_in(core_clk), .rst_n_in(rst_n), .cfg_in(cfg),
		.cfg_rdata_out(rdata), .cfg_busy_out(busy), .framing_mode_in(fmode),
		.serial_rx_in(rx), .serial_tx_out(tx), .serial_rx_ready_out(rx_rdy),
		.rx_error_out(err), .rf_tx_out(rft), .rf_tx_valid_out(rfv),
		.rf_tx_ready_in(rf_rdy), .rf_rx_data_in(rr_d), .rf_rx_valid_in(rr_v),
		.rf_rx_ready_out(rr_rdy));
	hsp_host_model HOST (.clk_in(core_clk), .line_in(tx), .line_out(rx));

	// =========================================================
	// helpers
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs

	task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			miscompares++;
			$display("wrong value %s expected %0h seen %0h", n, e, g);
		end
	endtask : check

	task automatic give_verdict();
		$display("checks %0d miscompares %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : give_verdict

	task automatic wr(input logic [1:0] s, input logic [31:0] d);
		@(negedge core_clk);
		cfg = '{1'b1, s, d};
		@(negedge core_clk);
		cfg.wr = 1'b0;
	endtask : wr

	// readback appears one cycle after the select
	task automatic rd(input logic [1:0] s, input logic [31:0] e, input string n);
		@(negedge core_clk);
		cfg.sel = s;
		@(negedge core_clk);
		check(n, e, rdata);
	endtask : rd

	task automatic put(input logic [7:0] d, input int p, input bit last);
		exp_q.push_back({d, last});
		HOST.send(d, p, 1'b0);
	endtask : put

	task automatic drain(input int lim, input int left);
		for (int i = 0; i < lim && exp_q.size() > left; i++) @(negedge core_clk);
		check("pending bytes", left, exp_q.size());
	endtask : drain

	// byte from the radio side out to the host; valid held until taken
	task automatic host_rx(input logic [7:0] d, input int p);
		logic [9:0] f;
		fork
			HOST.recv(f, p);
			begin
				@(negedge core_clk);
				rr_d = d;
				rr_v = 1'b1;
				while (rr_rdy !== 1'b1) @(negedge core_clk);
				@(negedge core_clk);
				rr_v = 1'b0;
			end
		join
		check("tx frame", {22'h0, 1'b1, HOST.pbit(p, d), d}, {22'h0, f});
	endtask : host_rx

	// =========================================================
	// sink stalls at random so back-pressure is exercised
	always @(negedge core_clk) rf_rdy <= !hold && (xs() & 32'h1) != 0;

	// reference queue compared at every accepted byte
	always @(posedge core_clk) begin
		if (rfv === 1'b1 && rf_rdy) begin
			check("rf_tx", (exp_q.size() > 0) ? 32'(exp_q.pop_front()) : 32'hFFFF,
				32'({rft.data, rft.last}));
		end
		if (err === 1'b1) errs++;
	end

	// =========================================================
	// main sequence
	initial begin
		logic [31:0] r;
		logic [31:0] dv;
		int          e;
		repeat (6) @(negedge core_clk);
		rst_n = 1'b1;
		rd(SEL_RATE, 32'h3, "rate reset");
		rd(SEL_PARITY, 32'h0, "parity reset");
		rd(SEL_TIMEOUT, 32'h3, "timeout reset");
		wr(SEL_RATE, 32'h8);
		rd(SEL_RATE, 32'h3, "rate refused");
		// random non-standard rates snap to what the divider can make
		for (int k = 0; k < 3; k++) begin
			dv = xs() % 32'h8;
			wr(SEL_RATE, dv);
			rd(SEL_RATE, dv, "rate code");
			r = 32'h39 + xs() % 32'hF4208;
			dv = (CLK_HZ + r / 2) / r;
			wr(SEL_RATE, r);
			check("busy", 1, busy);
			for (int i = 0; i < 200 && busy === 1'b1; i++) @(negedge core_clk);
			rd(SEL_RATE, (CLK_HZ + dv / 2) / dv, "snapped rate");
		end
		wr(SEL_RATE, 32'h7);
		rd(SEL_RATE, 32'h7, "rate code");
		wr(SEL_TIMEOUT, 32'h0);
		// every parity code, both directions, single-byte packets
		for (int p = 0; p < 5; p++) begin
			wr(SEL_PARITY, 32'(p));
			rd(SEL_PARITY, 32'(p), "parity");
			put(8'(xs()), p, 1'b1);
			drain(400, 0);
			host_rx(8'(xs()), p);
		end
		wr(SEL_PARITY, 32'h5);
		rd(SEL_PARITY, 32'h4, "parity refused");
		e = errs;
		HOST.send(8'h5A, 4, 1'b1);
		repeat (300) @(negedge core_clk);
		check("rx errors", e + 1, errs);
		// three back-to-back bytes held until three silent characters
		wr(SEL_PARITY, 32'h0);
		wr(SEL_TIMEOUT, 32'h3);
		put(8'h11, 0, 1'b0);
		put(8'h22, 0, 1'b0);
		put(8'h33, 0, 1'b1);
		repeat (3400) @(negedge core_clk);
		check("held bytes", 3, exp_q.size());
		drain(3000, 0);
		// non-raw framing discards input
		fmode = 2'h1;
		HOST.send(8'hA5, 0, 1'b0);
		repeat (300) @(negedge core_clk);
		fmode = 2'h0;
		// fill the buffer with the sink stalled, then drain it
		hold = 1'b1;
		wr(SEL_TIMEOUT, 32'hFF);
		// sixteen released at once, one parked at the sink, two more fill the last slots
		for (int i = 0; i < 18; i++) put(8'(xs()), 0, i == 15 || i == 17);
		repeat (50) @(negedge core_clk);
		check("room when full", 0, rx_rdy);
		HOST.send(8'hEE, 0, 1'b0);
		hold = 1'b0;
		drain(800, 2);
		wr(SEL_TIMEOUT, 32'h0);
		drain(400, 0);
		check("room when empty", 1, rx_rdy);
		give_verdict();
	end

	// watchdog sized well past the expected run
	initial begin
		#4_500_000;
		miscompares++;
		give_verdict();
	end
endmodule : test_host_serial_port_packetizer
`default_nettype wire
